// ==== spc_pkg.sv ====
// package for the special command engine: offsets, codes, reset values, carriers
package spc_pkg;
   localparam logic [7:0]  SPC_ADDR_PARAM_LOW  = 8'hb0;
   localparam logic [7:0]  SPC_ADDR_PARAM_HIGH = 8'hb1;
   localparam logic [7:0]  SPC_ADDR_RESULT     = 8'hb2;
   localparam logic [7:0]  SPC_ADDR_OPCODE     = 8'hb4;
   localparam logic [15:0] SPC_RST_WORD        = 16'h0000;
   localparam logic [7:0]  SPC_RST_OPCODE      = 8'h00;
   localparam logic [7:0]  SPC_CMD_STORE       = 8'h04;
   localparam logic [7:0]  SPC_CMD_STORE_PAIR  = 8'h08;
   localparam logic [7:0]  SPC_CMD_ADC_SPEED   = 8'h0d;
   localparam logic [7:0]  SPC_CMD_SETUP_TX    = 8'h0f;
   localparam logic [7:0]  SPC_CMD_LOAD_TX     = 8'h10;
   localparam logic [7:0]  SPC_CMD_RSSI_WIN    = 8'h12;
   localparam logic [7:0]  SPC_CMD_GAIN        = 8'h14;
   localparam logic [7:0]  SPC_CMD_MSG_LEN     = 8'h17;
   localparam logic [7:0]  SPC_CMD_EYE         = 8'h1f;
   localparam logic [15:0] SPC_EYE_ON          = 16'h0001;
   localparam logic [15:0] SPC_EYE_OFF         = 16'h0000;
   // adc time = (22*p + 1)/48 us, kept as multiplier and offset
   localparam logic [4:0]  SPC_ADC_MULT        = 5'h16;
   localparam logic [15:0] SPC_ADC_MIN         = 16'h0018;
   localparam logic [15:0] SPC_ADC_MAX         = 16'h0100;
   localparam logic [15:0] SPC_ADC_RST         = 16'h0018;
   localparam logic [15:0] SPC_GAIN_MAX        = 16'h7fff;
   localparam int          SPC_TABLE_DEPTH     = 64;
   localparam int          SPC_PTR_W           = 6;
   localparam logic [5:0]  SPC_TX_TABLE_BASE   = 6'h00;
   localparam logic [5:0]  SPC_TX_EVENTS       = 6'h08;

   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } spc_req_t;

   // settings handed to the rest of the chip
   typedef struct packed {
      logic [16:0] adc_convert_ticks;
      logic [15:0] rssi_start;
      logic [15:0] rssi_length;
      logic [15:0] rssi_gain;
      logic [15:0] carrier_sense_scale;
      logic        eye_monitor;
   } spc_cfg_t;
endpackage

// ==== spc_table.sv ====
// internal event table with one or two writes per cycle and one read port
`timescale 1ns/100ps
module spc_table (
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire logic                           we0,
   input  wire logic [spc_pkg::SPC_PTR_W-1:0]  addr0,
   input  wire logic [15:0]                    data0,
   input  wire logic                           we1,
   input  wire logic [spc_pkg::SPC_PTR_W-1:0]  addr1,
   input  wire logic [15:0]                    data1,
   input  wire logic [spc_pkg::SPC_PTR_W-1:0]  raddr,
   output logic      [15:0]                    rdata
);
   import spc_pkg::*;
   logic [15:0] mem [SPC_TABLE_DEPTH];

   // entries are not reset; software loads them before use
   always_ff @(posedge mclk) begin
      if (we0) begin
         mem[addr0] <= data0;
      end
      if (we1) begin
         mem[addr1] <= data1;
      end
   end

   // registered read, one cycle latency
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ==== spc_engine.sv ====
// special command engine: parameter, result and opcode registers plus command sequencer
// Functional notes
// - Two write-only 16-bit parameter words, a read-only 16-bit result and a write-only 8-bit opcode.
// - Writing the opcode while the engine is idle starts the selected command at once.
// - On finishing, the done flag is set, the opcode clears and any result is placed.
// - Code 04 stores the low parameter at the pointer and advances it by one.
// - Code 08 stores both parameters in two consecutive entries and advances by two.
// - Code 0D sets the adc conversion time from 22 times the parameter, clamped to 24..256, plus one, over 48 us.
// - Code 10 resets the pointer to the base of the transmit event table.
// - Code 0F walks the loaded transmit event table and configures transmit control.
// - Code 12 sets the rssi start sample and accumulated sample count.
// - Code 14 sets the rssi gain and carrier sense gain, each over 32768.
// - Code 17 waits for the message buffer then returns the message bit count.
// - Code 1F with 0001 routes receive demod signals to transmit I and Q; 0000 stops it.
`timescale 1ns/100ps
module spc_engine (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire spc_pkg::spc_req_t        req,
   output logic      [15:0]              rdata,
   output logic                          rvalid,
   input  wire logic                     irq_reg_read,
   output logic                          done_flag,
   output logic                          busy,
   input  wire logic                     msg_ready,
   input  wire logic [15:0]              msg_bits,
   output spc_pkg::spc_cfg_t             cfg,
   output logic      [15:0]              tx_event_data,
   output logic      [5:0]               tx_event_index,
   output logic                          tx_event_valid,
   output logic                          tx_config_done
);
   import spc_pkg::*;

   typedef enum logic [2:0] {
      SPC_IDLE,
      SPC_EXEC,
      SPC_WAIT_MSG,
      SPC_TX_READ,
      SPC_TX_EMIT,
      SPC_FINISH
   } spc_state_t;

   spc_state_t             state;
   logic [15:0]            param_low;
   logic [15:0]            param_high;
   logic [15:0]            result;
   logic [7:0]             opcode;
   logic [SPC_PTR_W-1:0]   ptr;
   logic [SPC_PTR_W-1:0]   tx_idx;
   logic [15:0]            tbl_rdata;
   logic                   tbl_we0;
   logic                   tbl_we1;
   logic                   op_write;
   logic                   finish;
   logic [16:0]            adc_ticks;
   logic [15:0]            win_start;
   logic [15:0]            win_length;
   logic [15:0]            sample_gain;
   logic [15:0]            carrier_sense_scale;
   logic                   eye_on;

   assign op_write = req.wr && (req.addr == SPC_ADDR_OPCODE) && (state == SPC_IDLE);
   assign finish   = (state == SPC_FINISH);
   assign tbl_we0  = (state == SPC_EXEC) && ((opcode == SPC_CMD_STORE) || (opcode == SPC_CMD_STORE_PAIR));
   assign tbl_we1  = (state == SPC_EXEC) && (opcode == SPC_CMD_STORE_PAIR);

   spc_table spc_table_inst (
      .mclk  (mclk),
      .rst   (rst),
      .we0   (tbl_we0),
      .addr0 (ptr),
      .data0 (param_low),
      .we1   (tbl_we1),
      .addr1 (SPC_PTR_W'(ptr + 6'h01)),
      .data1 (param_high),
      .raddr (tx_idx),
      .rdata (tbl_rdata)
   );

   // parameter words; writes while busy are dropped to protect the running command
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         param_low  <= SPC_RST_WORD;
         param_high <= SPC_RST_WORD;
      end else if (req.wr && !busy) begin
         if (req.addr == SPC_ADDR_PARAM_LOW) begin
            param_low <= req.wdata;
         end
         if (req.addr == SPC_ADDR_PARAM_HIGH) begin
            param_high <= req.wdata;
         end
      end
   end

   // opcode register, cleared by hardware when the command ends
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         opcode <= SPC_RST_OPCODE;
      end else if (finish) begin
         opcode <= SPC_RST_OPCODE;
      end else if (op_write) begin
         opcode <= req.wdata[7:0];
      end
   end

   // sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= SPC_IDLE;
      end else begin
         case (state)
            SPC_IDLE: begin
               if (op_write) begin
                  state <= SPC_EXEC;
               end
            end
            SPC_EXEC: begin
               if (opcode == SPC_CMD_MSG_LEN) begin
                  state <= SPC_WAIT_MSG;
               end else if (opcode == SPC_CMD_SETUP_TX) begin
                  state <= SPC_TX_READ;
               end else begin
                  state <= SPC_FINISH;
               end
            end
            SPC_WAIT_MSG: begin
               if (msg_ready) begin
                  state <= SPC_FINISH;
               end
            end
            SPC_TX_READ: begin
               state <= SPC_TX_EMIT;
            end
            SPC_TX_EMIT: begin
               if (tx_idx == SPC_TX_EVENTS - 6'h01) begin
                  state <= SPC_FINISH;
               end else begin
                  state <= SPC_TX_READ;
               end
            end
            SPC_FINISH: begin
               state <= SPC_IDLE;
            end
            default: begin
               state <= SPC_IDLE;
            end
         endcase
      end
   end

   // table pointer; store commands advance it, load_tx rewinds it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ptr <= SPC_TX_TABLE_BASE;
      end else if (state == SPC_EXEC) begin
         if (opcode == SPC_CMD_STORE) begin
            ptr <= SPC_PTR_W'(ptr + 6'h01);
         end else if (opcode == SPC_CMD_STORE_PAIR) begin
            ptr <= SPC_PTR_W'(ptr + 6'h02);
         end else if (opcode == SPC_CMD_LOAD_TX) begin
            ptr <= SPC_TX_TABLE_BASE;
         end
      end
   end

   // walk index; rewound on every command so a walk always starts at the table base
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_idx <= SPC_TX_TABLE_BASE;
      end else if (state == SPC_EXEC) begin
         tx_idx <= SPC_TX_TABLE_BASE;
      end else if (state == SPC_TX_EMIT) begin
         tx_idx <= SPC_PTR_W'(tx_idx + 6'h01);
      end
   end

   // event strobe out to the tx controller, one entry per read and emit pair
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_event_data  <= 16'h0000;
         tx_event_index <= 6'h00;
         tx_event_valid <= 1'b0;
         tx_config_done <= 1'b0;
      end else begin
         tx_event_valid <= 1'b0;
         tx_config_done <= 1'b0;
         if (state == SPC_TX_EMIT) begin
            tx_event_data  <= tbl_rdata;
            tx_event_index <= tx_idx;
            tx_event_valid <= 1'b1;
            tx_config_done <= (tx_idx == SPC_TX_EVENTS - 6'h01);
         end
      end
   end

   // adc conversion time in 1/48 us ticks; out-of-range words are clamped to SPC_ADC_MIN or SPC_ADC_MAX so the adc never runs too fast or too slow
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         adc_ticks <= 17'(SPC_ADC_RST * SPC_ADC_MULT + 17'h00001);
      end else if ((state == SPC_EXEC) && (opcode == SPC_CMD_ADC_SPEED)) begin
         if (param_low < SPC_ADC_MIN) begin
            adc_ticks <= 17'(SPC_ADC_MIN * SPC_ADC_MULT + 17'h00001);
         end else if (param_low > SPC_ADC_MAX) begin
            adc_ticks <= 17'(SPC_ADC_MAX * SPC_ADC_MULT + 17'h00001);
         end else begin
            adc_ticks <= 17'({1'b0, param_low} * SPC_ADC_MULT + 17'h00001);
         end
      end
   end

   // rssi measurement window, shared by both receive channels
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         win_start  <= SPC_RST_WORD;
         win_length <= SPC_RST_WORD;
      end else if ((state == SPC_EXEC) && (opcode == SPC_CMD_RSSI_WIN)) begin
         win_start  <= param_low;
         win_length <= param_high;
      end
   end

   // gains; top bit dropped because the factors are q15 fractions below one
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sample_gain         <= SPC_RST_WORD;
         carrier_sense_scale <= SPC_RST_WORD;
      end else if ((state == SPC_EXEC) && (opcode == SPC_CMD_GAIN)) begin
         sample_gain         <= param_low & SPC_GAIN_MAX;
         carrier_sense_scale <= param_high & SPC_GAIN_MAX;
      end
   end

   // eye monitor routing; words other than on and off leave it as it was
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         eye_on <= 1'b0;
      end else if ((state == SPC_EXEC) && (opcode == SPC_CMD_EYE)) begin
         if (param_low == SPC_EYE_ON) begin
            eye_on <= 1'b1;
         end else if (param_low == SPC_EYE_OFF) begin
            eye_on <= 1'b0;
         end
      end
   end

   // settings bundle; each field is wired straight from its own register
   assign cfg = '{
      adc_convert_ticks:   adc_ticks,
      rssi_start:          win_start,
      rssi_length:         win_length,
      rssi_gain:           sample_gain,
      carrier_sense_scale: carrier_sense_scale,
      eye_monitor:         eye_on
   };

   // result word, loaded at completion of the length query
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result <= SPC_RST_WORD;
      end else if ((state == SPC_WAIT_MSG) && msg_ready) begin
         result <= msg_bits;
      end
   end

   // done flag: set wins over a same-cycle interrupt register read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_flag <= 1'b0;
      end else if (finish) begin
         done_flag <= 1'b1;
      end else if (irq_reg_read) begin
         done_flag <= 1'b0;
      end
   end

   // busy from the opcode write until the done flag rises
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (finish) begin
         busy <= 1'b0;
      end else if (op_write) begin
         busy <= 1'b1;
      end
   end

   // read port: only the result is readable, everything else reads zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata  <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         rdata  <= (req.rd && (req.addr == SPC_ADDR_RESULT)) ? result : 16'h0000;
      end
   end
endmodule

// ==== spc_engine_properties.sv ====
// port assertions for the special command engine, bound into each engine
`timescale 1ns/100ps
module spc_engine_properties (
   input wire logic              mclk,
   input wire logic              rst,
   input wire spc_pkg::spc_req_t req,
   input wire logic [15:0]       rdata,
   input wire logic              rvalid,
   input wire logic              irq_reg_read,
   input wire logic              done_flag,
   input wire logic              busy,
   input wire spc_pkg::spc_cfg_t cfg
);
   import spc_pkg::*;
   logic [15:0] plow;
   // shadow of the accepted low parameter; writes while busy are dropped
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         plow <= SPC_RST_WORD;
      end else if (req.wr && !busy && req.addr == SPC_ADDR_PARAM_LOW) begin
         plow <= req.wdata;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // an opcode write taken by the idle engine
   sequence s_go(logic [7:0] c);
      req.wr && !busy && req.addr == SPC_ADDR_OPCODE && req.wdata[7:0] == c;
   endsequence
   sequence s_any_go;
      req.wr && !busy && req.addr == SPC_ADDR_OPCODE;
   endsequence
   property p_start; s_any_go |=> busy; endproperty
   a_start: assert property (p_start) else $error("opcode write left engine idle");
   property p_store_end; s_go(SPC_CMD_STORE) |-> ##[2:4] done_flag; endproperty
   a_store_end: assert property (p_store_end) else $error("store never finished");
   property p_fall_done; $fell(busy) |-> done_flag; endproperty
   a_fall_done: assert property (p_fall_done) else $error("command ended without done");
   property p_hold; done_flag && !irq_reg_read |=> done_flag; endproperty
   a_hold: assert property (p_hold) else $error("done dropped without a read");
   property p_clear; irq_reg_read && !busy |=> !done_flag; endproperty
   a_clear: assert property (p_clear) else $error("done survived a read");
   property p_rd_zero; req.rd && req.addr != SPC_ADDR_RESULT |=> rvalid && rdata == 16'h0000; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("write-only read not zero");
   // clamp range excluded: only documented values are tied to the formula
   property p_adc;
      s_go(SPC_CMD_ADC_SPEED) ##0 (plow >= SPC_ADC_MIN && plow <= SPC_ADC_MAX)
         |-> ##4 cfg.adc_convert_ticks == 17'(32'(plow) * 32'(SPC_ADC_MULT) + 32'h1);
   endproperty
   a_adc: assert property (p_adc) else $error("adc time wrong");
   property p_gain; s_go(SPC_CMD_GAIN) |-> ##4 cfg.rssi_gain == {1'b0, plow[14:0]}; endproperty
   a_gain: assert property (p_gain) else $error("rssi gain wrong");
   property p_eye; s_go(SPC_CMD_EYE) ##0 plow == SPC_EYE_ON |-> ##4 cfg.eye_monitor; endproperty
   a_eye: assert property (p_eye) else $error("eye monitor not on");
   property p_quiet; !busy ##1 !busy |-> $stable(cfg); endproperty
   a_quiet: assert property (p_quiet) else $error("settings moved while idle");
endmodule
bind spc_engine spc_engine_properties spc_engine_properties_inst (.mclk(mclk), .rst(rst), .req(req),
   .rdata(rdata), .rvalid(rvalid), .irq_reg_read(irq_reg_read), .done_flag(done_flag), .busy(busy), .cfg(cfg));

// ==== spc_host.sv ====
// host model: register accesses, interrupt register reads, message buffer
`timescale 1ns/100ps
module spc_host (
   input  wire logic         mclk,
   input  wire logic         done_flag,
   output spc_pkg::spc_req_t req,
   output logic              irq_reg_read,
   output logic              msg_ready,
   output logic [15:0]       msg_bits
);
   import spc_pkg::*;
   // idle port; no stale count while the buffer is not ready
   initial begin
      req = '0;
      irq_reg_read = 1'b0;
      msg_ready = 1'b0;
      msg_bits = 16'hffff;
   end
   // one strobe cycle per access; released lines show the inverse, not the old value
   task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // parameters always go ahead of the opcode
   task automatic command(input logic [7:0] c, input logic [15:0] p0, input logic [15:0] p1);
      access(1'b1, SPC_ADDR_PARAM_LOW, p0);
      access(1'b1, SPC_ADDR_PARAM_HIGH, p1);
      access(1'b1, SPC_ADDR_OPCODE, {8'h00, c});
   endtask
   // nothing more is written until done shows; bounded so a hang cannot stall
   task automatic wait_done();
      for (int i = 0; i < 200 && done_flag !== 1'b1; i++)
         @(posedge mclk);
   endtask
   task automatic ack();
      @(posedge mclk);
      irq_reg_read <= 1'b1;
      @(posedge mclk);
      irq_reg_read <= 1'b0;
   endtask
   task automatic set_msg(input logic r, input logic [15:0] b);
      @(posedge mclk);
      msg_ready <= r;
      msg_bits <= r ? b : ~b;
   endtask
endmodule

// ==== special_command_interface_test.sv ====
// self-checking bench for the special command engine against an integer model
`timescale 1ns/100ps
module special_command_interface_test;
   import spc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst;
   spc_req_t    req;
   logic [15:0] rdata;
   logic        rvalid;
   logic        irq_reg_read;
   logic        done_flag;
   logic        busy;
   logic        msg_ready;
   logic [15:0] msg_bits;
   spc_cfg_t    cfg;
   logic [15:0] tx_event_data;
   logic [5:0]  tx_event_index;
   logic        tx_event_valid;
   logic        tx_config_done;
   logic [15:0] bits;
   int          n_errors = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          tbl[64];
   int          ptr = 0;
   int          evq[$];
   int          ends = 0;
   int          e_adc = 22 * SPC_ADC_RST + 1;
   int          e_start = 0;
   int          e_len = 0;
   int          e_gain = 0;
   int          e_cs = 0;
   int          e_eye = 0;
   spc_engine spc_engine_inst (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .irq_reg_read(irq_reg_read), .done_flag(done_flag), .busy(busy), .msg_ready(msg_ready),
      .msg_bits(msg_bits), .cfg(cfg), .tx_event_data(tx_event_data), .tx_event_index(tx_event_index),
      .tx_event_valid(tx_event_valid), .tx_config_done(tx_config_done));
   spc_host spc_host_inst (.mclk(mclk), .done_flag(done_flag), .req(req), .irq_reg_read(irq_reg_read),
      .msg_ready(msg_ready), .msg_bits(msg_bits));
   always #2.5 mclk = ~mclk;
   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // event capture plus a runaway guard so a hung handshake still reports
   always @(posedge mclk) begin
      cycles++;
      if (tx_event_valid === 1'b1)
         evq.push_back({tx_event_index, tx_event_data});
      if (tx_config_done === 1'b1)
         ends++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      spc_host_inst.access(1'b0, a, 16'h0000);
      @(posedge mclk);
      check(rvalid, 1'b1);
      check(rdata, e);
   endtask
   task automatic cmp_cfg();
      check(cfg.adc_convert_ticks, e_adc);
      check(cfg.rssi_start, e_start);
      check(cfg.rssi_length, e_len);
      check(cfg.rssi_gain, e_gain);
      check(cfg.carrier_sense_scale, e_cs);
      check(cfg.eye_monitor, e_eye);
   endtask
   // done must stand until the interrupt register read, then drop
   task automatic settle();
      repeat (3) @(posedge mclk);
      check(done_flag, 1'b1);
      spc_host_inst.ack();
      @(posedge mclk);
      check(done_flag, 1'b0);
   endtask
   task automatic model(input logic [7:0] c, input int p0, input int p1);
      case (c)
         SPC_CMD_STORE: begin
            tbl[ptr] = p0;
            ptr = (ptr + 1) % SPC_TABLE_DEPTH;
         end
         SPC_CMD_STORE_PAIR: begin
            tbl[ptr] = p0;
            tbl[(ptr + 1) % SPC_TABLE_DEPTH] = p1;
            ptr = (ptr + 2) % SPC_TABLE_DEPTH;
         end
         SPC_CMD_LOAD_TX: ptr = SPC_TX_TABLE_BASE;
         SPC_CMD_ADC_SPEED: e_adc = 22 * p0 + 1;
         SPC_CMD_RSSI_WIN: begin
            e_start = p0;
            e_len = p1;
         end
         SPC_CMD_GAIN: begin
            e_gain = p0;
            e_cs = p1;
         end
         SPC_CMD_EYE: if (p0 <= 1) e_eye = p0;
         default: ;
      endcase
   endtask
   task automatic cmd(input logic [7:0] c, input logic [15:0] p0, input logic [15:0] p1);
      spc_host_inst.command(c, p0, p1);
      spc_host_inst.wait_done();
      settle();
      model(c, p0, p1);
      cmp_cfg();
   endtask
   initial begin
      void'($urandom(32'h5b46));
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      cmp_cfg();
      rd(SPC_ADDR_RESULT, SPC_RST_WORD);
      rd(SPC_ADDR_PARAM_LOW, 16'h0000);
      rd(8'hb5, 16'h0000);
      $display("test reset finished");
      // fill the event table with singles and pairs, then interpret it
      cmd(SPC_CMD_LOAD_TX, 16'h0000, 16'h0000);
      for (int i = 0; i < 2; i++)
         cmd(SPC_CMD_STORE, 16'($urandom), 16'($urandom));
      for (int i = 0; i < 3; i++)
         cmd(SPC_CMD_STORE_PAIR, 16'($urandom), 16'($urandom));
      evq.delete();
      cmd(SPC_CMD_SETUP_TX, 16'h0000, 16'h0000);
      check(evq.size(), SPC_TX_EVENTS);
      check(ends, 1);
      foreach (evq[i])
         check(evq[i], {SPC_TX_TABLE_BASE + 6'(i), 16'(tbl[i])});
      $display("test table finished");
      // settings commands at boundaries and random in-range values
      cmd(SPC_CMD_ADC_SPEED, SPC_ADC_MIN, 16'h0000);
      cmd(SPC_CMD_ADC_SPEED, SPC_ADC_MAX, 16'h0000);
      cmd(SPC_CMD_ADC_SPEED, 16'(24 + $urandom % 233), 16'h0000);
      cmd(SPC_CMD_RSSI_WIN, 16'($urandom), 16'($urandom));
      cmd(SPC_CMD_GAIN, SPC_GAIN_MAX, 16'h0000);
      cmd(SPC_CMD_GAIN, 16'($urandom) & SPC_GAIN_MAX, 16'($urandom) & SPC_GAIN_MAX);
      cmd(SPC_CMD_EYE, SPC_EYE_ON, 16'h0000);
      cmd(SPC_CMD_EYE, 16'h0005, 16'h0000);
      cmd(SPC_CMD_EYE, SPC_EYE_OFF, 16'h0000);
      // only listed codes are issued; a rewind with stray parameters must leave the settings alone
      cmd(SPC_CMD_LOAD_TX, 16'h1234, 16'h5678);
      $display("test settings finished");
      // a parameter write while busy must not reach the running command
      spc_host_inst.command(SPC_CMD_ADC_SPEED, 16'h0064, 16'h0000);
      spc_host_inst.access(1'b1, SPC_ADDR_PARAM_LOW, 16'h00c8);
      spc_host_inst.wait_done();
      settle();
      model(SPC_CMD_ADC_SPEED, 16'h0064, 16'h0000);
      cmp_cfg();
      // message length waits on a slow buffer, then returns the count
      spc_host_inst.command(SPC_CMD_MSG_LEN, 16'h0000, 16'h0000);
      repeat (10) @(posedge mclk);
      check(done_flag, 1'b0);
      bits = 16'($urandom);
      spc_host_inst.set_msg(1'b1, bits);
      spc_host_inst.wait_done();
      settle();
      spc_host_inst.set_msg(1'b0, bits);
      rd(SPC_ADDR_RESULT, bits);
      $display("test busy and length finished");
      final_report();
   end
endmodule
